// file: design/ptq_pkg.sv
/*
 Constants for the egress timestamp qualifier: register offsets, field
 positions and reset values, and a shared helper function.
 Assumes nothing of its surroundings beyond a SystemVerilog compiler.
*/
`default_nettype none

package ptq_pkg;

    // Register byte offsets
    localparam logic [11:0] PTQ_SEL_OFFSET = 12'h100;
    localparam logic [11:0] PTQ_STAT_OFFSET = 12'h104;
    localparam logic [11:0] PTQ_CFG_OFFSET = 12'h15C;

    // Bank and port select register layout
    localparam int PTQ_BANK_LSB = 0;
    localparam int PTQ_BANK_W = 3;
    localparam int PTQ_PORT_LSB = 4;
    localparam int PTQ_PORT_W = 2;
    localparam logic [2:0] PTQ_PORT_BANK = 3'h2;
    localparam logic [31:0] PTQ_SEL_RESET = 32'h0000_0000;

    // Status register layout
    localparam int PTQ_STAT_CAP_LSB = 0;
    localparam int PTQ_STAT_REJ_LSB = 8;

    // Qualification config layout
    localparam int PTQ_DOMAIN_LSB = 24;
    localparam int PTQ_DOMAIN_W = 8;
    localparam int PTQ_DOMAIN_EN_BIT = 23;
    localparam int PTQ_ALT_CHECK_BIT = 22;
    localparam int PTQ_UDP_BYPASS_BIT = 21;
    localparam int PTQ_CRC_BYPASS_BIT = 20;
    localparam int PTQ_VERSION_LSB = 16;
    localparam int PTQ_VERSION_W = 4;
    localparam int PTQ_MASK_LSB = 0;
    localparam int PTQ_MASK_W = 16;

    // Field reset values
    localparam logic [7:0] PTQ_DOMAIN_RESET = 8'h00;
    localparam logic PTQ_DOMAIN_EN_RESET = 1'b0;
    localparam logic PTQ_ALT_CHECK_RESET = 1'b0;
    localparam logic PTQ_UDP_BYPASS_RESET = 1'b0;
    localparam logic PTQ_CRC_BYPASS_RESET = 1'b0;
    localparam logic [3:0] PTQ_VERSION_RESET = 4'h2;
    localparam logic [3:0] PTQ_VERSION_ANY = 4'h0;
    localparam logic [15:0] PTQ_MASK_RESET = 16'h0000;

    localparam logic [31:0] PTQ_CFG_RESET = {PTQ_DOMAIN_RESET, PTQ_DOMAIN_EN_RESET, PTQ_ALT_CHECK_RESET,
                                             PTQ_UDP_BYPASS_RESET, PTQ_CRC_BYPASS_RESET,
                                             PTQ_VERSION_RESET, PTQ_MASK_RESET};

    // Merge write data into a word under APB byte strobes
    function automatic logic [31:0] ptq_merge(input logic [31:0] old_val, input logic [31:0] wdata,
                                              input logic [3:0] strb);
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = wdata[b*8 +: 8];
            end
        end
        return res;
    endfunction

endpackage

`default_nettype wire

// file: design/ptq_check.sv
/*
 One port's qualification decision: compares the parsed header fields of a
 finished egress frame against the port's config word.
 Assumes the datapath gives a one-cycle strobe with all fields valid with it.
*/
`timescale 1ns/1ps
`default_nettype none

module ptq_check
    import ptq_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // Config word of this port
    input wire logic [31:0] cfg_i,
    // Frame results from the transmit datapath
    input wire logic frame_valid_i,
    input wire logic [7:0] domain_i,
    input wire logic alt_flag_i,
    input wire logic udp_sum_ok_i,
    input wire logic crc_ok_i,
    input wire logic [3:0] version_i,
    input wire logic [3:0] msg_type_i,
    // Decision pulses
    output logic capture_o,
    output logic reject_o
);

    logic capture_q;
    logic capture_d;
    logic reject_q;
    logic reject_d;
    logic domain_ok;
    logic alt_ok;
    logic udp_ok;
    logic crc_ok;
    logic version_ok;
    logic type_ok;
    logic [3:0] cfg_version;

    always_comb begin
        cfg_version = cfg_i[PTQ_VERSION_LSB +: PTQ_VERSION_W];
        domain_ok = !cfg_i[PTQ_DOMAIN_EN_BIT] ||
                    (domain_i == cfg_i[PTQ_DOMAIN_LSB +: PTQ_DOMAIN_W]);
        alt_ok = !cfg_i[PTQ_ALT_CHECK_BIT] || !alt_flag_i;
        udp_ok = cfg_i[PTQ_UDP_BYPASS_BIT] || udp_sum_ok_i;
        crc_ok = cfg_i[PTQ_CRC_BYPASS_BIT] || crc_ok_i;
        version_ok = (cfg_version == PTQ_VERSION_ANY) || (version_i == cfg_version);
        type_ok = cfg_i[PTQ_MASK_LSB + 32'(msg_type_i)];
        capture_d = frame_valid_i && domain_ok && alt_ok && udp_ok && crc_ok && version_ok && type_ok;
        reject_d = frame_valid_i && !capture_d;
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            capture_q <= 1'b0;
            reject_q <= 1'b0;
        end else begin
            capture_q <= capture_d;
            reject_q <= reject_d;
        end
    end

    assign capture_o = capture_q;
    assign reject_o = reject_q;

endmodule // ptq_check

`default_nettype wire

// file: design/ptq_qualifier.sv
/*
 Egress timestamp qualifier for all switch ports: APB register slave with a
 bank/port select, one config word per port, and one decision per frame.
 Assumes frame results arrive on clock_i from the transmit datapath and
 that software leaves the config alone while timestamping is enabled.
*/
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Domain match enable compares message domainNumber
// - Domain mismatch blocks capture; domain resets zero
// - Alternate-master check needs flag zero
// - Bad UDP checksum blocks unless bypassed
// - Bad FCS blocks unless bypassed
// - Version must match; zero accepts any
// - Message type mask bit must be set
// - One config copy per port, bank/port selected
module ptq_qualifier
    import ptq_pkg::*;
#(
    parameter int NUM_PORTS = 3
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // APB slave
    input wire logic [11:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Frame results, one slice per port
    input wire logic [NUM_PORTS-1:0] frame_valid_i,
    input wire logic [NUM_PORTS*8-1:0] frame_domain_i,
    input wire logic [NUM_PORTS-1:0] frame_alt_flag_i,
    input wire logic [NUM_PORTS-1:0] frame_udp_sum_ok_i,
    input wire logic [NUM_PORTS-1:0] frame_crc_ok_i,
    input wire logic [NUM_PORTS*4-1:0] frame_version_i,
    input wire logic [NUM_PORTS*4-1:0] frame_msg_type_i,
    // Decisions to the capture store
    output logic [NUM_PORTS-1:0] ts_capture_o,
    output logic [NUM_PORTS-1:0] ts_reject_o
);

    // APB state, registers and status
    logic [31:0] sel_q;
    logic [31:0] sel_d;
    logic [31:0] cfg_q [NUM_PORTS];
    logic [31:0] cfg_d [NUM_PORTS];
    logic [NUM_PORTS-1:0] last_cap_q;
    logic [NUM_PORTS-1:0] last_cap_d;
    logic [NUM_PORTS-1:0] last_rej_q;
    logic [NUM_PORTS-1:0] last_rej_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;

    logic [PTQ_BANK_W-1:0] bank_sel;
    logic [PTQ_PORT_W-1:0] port_sel;
    logic port_hit;
    logic setup;
    logic wr_commit;
    logic [NUM_PORTS-1:0] cap_pulse;
    logic [NUM_PORTS-1:0] rej_pulse;
    logic [31:0] stat_word;

    always_comb begin
        bank_sel = sel_q[PTQ_BANK_LSB +: PTQ_BANK_W];
        port_sel = sel_q[PTQ_PORT_LSB +: PTQ_PORT_W];
        port_hit = (bank_sel == PTQ_PORT_BANK) && (32'(port_sel) < NUM_PORTS);
        setup = psel_i && !penable_i;
        wr_commit = psel_i && penable_i && pready_q && pwrite_i;
        stat_word = 32'h0000_0000;
        stat_word[PTQ_STAT_CAP_LSB +: NUM_PORTS] = last_cap_q;
        stat_word[PTQ_STAT_REJ_LSB +: NUM_PORTS] = last_rej_q;
    end

    // APB answer: one wait-free access phase after every setup
    always_comb begin
        pready_d = setup;
        pslverr_d = 1'b0;
        prdata_d = 32'h0000_0000;
        if (setup) begin
            unique case (paddr_i)
                PTQ_SEL_OFFSET: begin
                    prdata_d = pwrite_i ? 32'h0000_0000 : sel_q;
                end
                PTQ_STAT_OFFSET: begin
                    prdata_d = pwrite_i ? 32'h0000_0000 : stat_word;
                    pslverr_d = pwrite_i;
                end
                PTQ_CFG_OFFSET: begin
                    if (port_hit && !pwrite_i) begin
                        prdata_d = cfg_q[port_sel];
                    end
                end
                default: begin
                    pslverr_d = 1'b1;
                end
            endcase
        end
    end

    // Register writes, committed at the access-phase edge
    always_comb begin
        sel_d = sel_q;
        for (int p = 0; p < NUM_PORTS; p++) begin
            cfg_d[p] = cfg_q[p];
        end
        if (wr_commit && paddr_i == PTQ_SEL_OFFSET) begin
            sel_d = ptq_merge(sel_q, pwdata_i, pstrb_i);
            sel_d[31:PTQ_PORT_LSB + PTQ_PORT_W] = '0;
            sel_d[PTQ_PORT_LSB - 1:PTQ_BANK_W] = '0;
        end
        if (wr_commit && paddr_i == PTQ_CFG_OFFSET && port_hit) begin
            cfg_d[port_sel] = ptq_merge(cfg_q[port_sel], pwdata_i, pstrb_i);
        end
    end

    // Last decision per port, latched from each verdict
    always_comb begin
        last_cap_d = last_cap_q;
        last_rej_d = last_rej_q;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (cap_pulse[p] || rej_pulse[p]) begin
                last_cap_d[p] = cap_pulse[p];
                last_rej_d[p] = rej_pulse[p];
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            sel_q <= PTQ_SEL_RESET;
            for (int p = 0; p < NUM_PORTS; p++) begin
                cfg_q[p] <= PTQ_CFG_RESET;
            end
            last_cap_q <= '0;
            last_rej_q <= '0;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            sel_q <= sel_d;
            for (int p = 0; p < NUM_PORTS; p++) begin
                cfg_q[p] <= cfg_d[p];
            end
            last_cap_q <= last_cap_d;
            last_rej_q <= last_rej_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // One decision unit per port
    for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
        ptq_check u_check (
            .clock_i(clock_i),
            .sys_rst_i(sys_rst_i),
            .cfg_i(cfg_q[g]),
            .frame_valid_i(frame_valid_i[g]),
            .domain_i(frame_domain_i[g*8 +: 8]),
            .alt_flag_i(frame_alt_flag_i[g]),
            .udp_sum_ok_i(frame_udp_sum_ok_i[g]),
            .crc_ok_i(frame_crc_ok_i[g]),
            .version_i(frame_version_i[g*4 +: 4]),
            .msg_type_i(frame_msg_type_i[g*4 +: 4]),
            .capture_o(cap_pulse[g]),
            .reject_o(rej_pulse[g])
        );
    end

    assign ts_capture_o = cap_pulse;
    assign ts_reject_o = rej_pulse;
    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;

endmodule // ptq_qualifier

`default_nettype wire

// file: dv/ptq_qualifier_sva.sv
/* Checker for the egress qualifier: APB timing and port 0 verdicts.
 Assumes software writes whole words with all strobes set. */
`timescale 1ns/1ps
`default_nettype none
module ptq_qualifier_sva
    import ptq_pkg::*;
#(
    parameter int NUM_PORTS = 3
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // APB
    input wire logic [11:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Frames and verdicts
    input wire logic [NUM_PORTS-1:0] frame_valid_i,
    input wire logic [NUM_PORTS*8-1:0] frame_domain_i,
    input wire logic [NUM_PORTS-1:0] frame_alt_flag_i,
    input wire logic [NUM_PORTS-1:0] frame_udp_sum_ok_i,
    input wire logic [NUM_PORTS-1:0] frame_crc_ok_i,
    input wire logic [NUM_PORTS*4-1:0] frame_version_i,
    input wire logic [NUM_PORTS*4-1:0] frame_msg_type_i,
    input wire logic [NUM_PORTS-1:0] ts_capture_o,
    input wire logic [NUM_PORTS-1:0] ts_reject_o
);
    logic [31:0] sel_q;
    logic [31:0] cfg_q;
    logic ok_dom, ok_alt, ok_udp, ok_crc, ok_ver, ok_typ, fv;
    // Shadow of port 0 config
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            sel_q <= PTQ_SEL_RESET;
            cfg_q <= PTQ_CFG_RESET;
        end else if (psel_i && penable_i && pready_o && pwrite_i) begin
            if (paddr_i == PTQ_SEL_OFFSET) sel_q <= pwdata_i;
            if (paddr_i == PTQ_CFG_OFFSET && sel_q[2:0] == PTQ_PORT_BANK && sel_q[5:4] == 2'h0) cfg_q <= pwdata_i;
        end
    end
    assign fv = frame_valid_i[0];
    assign ok_dom = !cfg_q[23] || frame_domain_i[7:0] == cfg_q[31:24];
    assign ok_alt = !cfg_q[22] || !frame_alt_flag_i[0];
    assign ok_udp = cfg_q[21] || frame_udp_sum_ok_i[0];
    assign ok_crc = cfg_q[20] || frame_crc_ok_i[0];
    assign ok_ver = cfg_q[19:16] == 4'h0 || frame_version_i[3:0] == cfg_q[19:16];
    assign ok_typ = cfg_q[frame_msg_type_i[3:0]];
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    a_pready_after_setup: assert property (psel_i && !penable_i |=> pready_o) else $error("no pready");
    a_pready_only_access: assert property (pready_o |-> $past(psel_i && !penable_i)) else $error("stray pready");
    a_cfg_no_error: assert property (pready_o && paddr_i == PTQ_CFG_OFFSET |-> !pslverr_o) else $error("cfg err");
    a_one_verdict: assert property (fv |=> ts_capture_o[0] != ts_reject_o[0]) else $error("verdict");
    a_no_frame_quiet: assert property (!fv |=> !ts_capture_o[0] && !ts_reject_o[0]) else $error("stray");
    a_domain_blocks: assert property (fv && !ok_dom |=> ts_reject_o[0]) else $error("domain");
    a_alt_blocks: assert property (fv && !ok_alt |=> ts_reject_o[0]) else $error("alt flag");
    a_udp_blocks: assert property (fv && !ok_udp |=> ts_reject_o[0]) else $error("udp sum");
    a_crc_blocks: assert property (fv && !ok_crc |=> ts_reject_o[0]) else $error("fcs");
    a_version_blocks: assert property (fv && !ok_ver |=> ts_reject_o[0]) else $error("version");
    a_type_blocks: assert property (fv && !ok_typ |=> ts_reject_o[0]) else $error("type mask");
    a_all_pass: assert property (fv && ok_dom && ok_alt && ok_udp && ok_crc && ok_ver && ok_typ
                                 |=> ts_capture_o[0]) else $error("capture");
    c_capture: cover property (fv ##1 ts_capture_o[0]);
    c_reject: cover property (fv ##1 ts_reject_o[0]);
    c_slverr: cover property (pready_o && pslverr_o);
endmodule // ptq_qualifier_sva
bind ptq_qualifier ptq_qualifier_sva #(.NUM_PORTS(NUM_PORTS)) u_sva (.clock_i, .sys_rst_i, .paddr_i, .psel_i,
    .penable_i, .pwrite_i, .pwdata_i, .pready_o, .pslverr_o, .frame_valid_i, .frame_domain_i, .frame_alt_flag_i,
    .frame_udp_sum_ok_i, .frame_crc_ok_i, .frame_version_i, .frame_msg_type_i, .ts_capture_o, .ts_reject_o);
`default_nettype wire

// file: dv/ptq_tx_model.sv
/* Transmit datapath model: one-cycle frame strobe with parsed fields.
 Assumes the caller waits for one send to end before the next. */
`timescale 1ns/1ps
`default_nettype none
module ptq_tx_model #(
    parameter int NUM_PORTS = 3
) (
    // Clock
    input wire logic clock_i,
    // Frame results
    output logic [NUM_PORTS-1:0] valid_o,
    output logic [NUM_PORTS*8-1:0] dom_o,
    output logic [NUM_PORTS-1:0] alt_o,
    output logic [NUM_PORTS-1:0] udp_o,
    output logic [NUM_PORTS-1:0] crc_o,
    output logic [NUM_PORTS*4-1:0] ver_o,
    output logic [NUM_PORTS*4-1:0] typ_o
);
    initial begin
        {valid_o, dom_o, alt_o, udp_o, crc_o, ver_o, typ_o} = '0;
    end
    task automatic send(input int p, input logic [7:0] d, input logic a, input logic u, input logic c,
                        input logic [3:0] v, input logic [3:0] t);
        @(posedge clock_i);
        valid_o[p] <= 1'b1;
        dom_o[p*8 +: 8] <= d;
        alt_o[p] <= a;
        udp_o[p] <= u;
        crc_o[p] <= c;
        ver_o[p*4 +: 4] <= v;
        typ_o[p*4 +: 4] <= t;
        @(posedge clock_i);
        valid_o <= '0;
        // Fields are meaningless off the strobe
        {dom_o, alt_o, udp_o, crc_o, ver_o, typ_o} <= ~{dom_o, alt_o, udp_o, crc_o, ver_o, typ_o};
    endtask
endmodule // ptq_tx_model
`default_nettype wire

// file: dv/ptq_qualifier_bench.sv
/* Testbench for the egress qualifier: APB master and frame scenarios.
 Assumes the model in ptq_tx_model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module ptq_qualifier_bench
    import ptq_pkg::*;
;
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [11:0] paddr = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic [2:0] fv, fa, fu, fc, cap, rej;
    logic [23:0] fd;
    logic [11:0] fver, ft;
    int fail_count = 0;
    int tests_run = 0;
    always #2 clock_i = ~clock_i;
    ptq_tx_model #(.NUM_PORTS(3)) model (.clock_i(clock_i), .valid_o(fv), .dom_o(fd), .alt_o(fa), .udp_o(fu),
        .crc_o(fc), .ver_o(fver), .typ_o(ft));
    ptq_qualifier #(.NUM_PORTS(3)) dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .paddr_i(paddr),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .pstrb_i(4'hF),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .frame_valid_i(fv), .frame_domain_i(fd),
        .frame_alt_flag_i(fa), .frame_udp_sum_ok_i(fu), .frame_crc_ok_i(fc), .frame_version_i(fver),
        .frame_msg_type_i(ft), .ts_capture_o(cap), .ts_reject_o(rej));
    task automatic results;
        $display("%0d comparisons, %0d mismatches", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
        int n;
        n = 0;
        @(posedge clock_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        // Request held until pready is seen high at a rising edge
        do begin
            @(posedge clock_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fail_count++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic e;
        apb(1'b1, a, d, rd, e);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
        logic [31:0] rd;
        logic e;
        apb(1'b0, a, 32'h0, rd, e);
        check(rd, exp);
        check(32'(e), 32'(eerr));
    endtask
    task automatic frm(input int p, input logic [7:0] d, input logic a, input logic u, input logic c,
                       input logic [3:0] v, input logic [3:0] t, input logic ec);
        model.send(p, d, a, u, c, v, t);
        #1;
        check(32'({cap[p], rej[p]}), ec ? 32'h2 : 32'h1);
    endtask
    task automatic t_reset;
        rdchk(PTQ_SEL_OFFSET, 32'h0, 1'b0);
        wr(PTQ_SEL_OFFSET, 32'h2);
        rdchk(PTQ_CFG_OFFSET, 32'h0002_0000, 1'b0);
        frm(0, 8'h00, 1'b0, 1'b1, 1'b1, 4'h2, 4'h0, 1'b0);
        $display("reset test done");
    endtask
    task automatic t_mask;
        for (int i = 0; i < 16; i++) begin
            wr(PTQ_CFG_OFFSET, 32'h1 << i);
            frm(0, 8'h00, 1'b0, 1'b1, 1'b1, 4'(i + 3), 4'(i), 1'b1);
            frm(0, 8'h00, 1'b0, 1'b1, 1'b1, 4'h2, 4'(i + 1), 1'b0);
        end
        $display("type mask test done");
    endtask
    task automatic t_checks;
        wr(PTQ_CFG_OFFSET, 32'h5AC2_000F);
        frm(0, 8'h5A, 1'b0, 1'b1, 1'b1, 4'h2, 4'h0, 1'b1);
        frm(0, 8'h5B, 1'b0, 1'b1, 1'b1, 4'h2, 4'h0, 1'b0);
        frm(0, 8'h5A, 1'b1, 1'b1, 1'b1, 4'h2, 4'h1, 1'b0);
        frm(0, 8'h5A, 1'b0, 1'b0, 1'b1, 4'h2, 4'h2, 1'b0);
        frm(0, 8'h5A, 1'b0, 1'b1, 1'b0, 4'h2, 4'h3, 1'b0);
        frm(0, 8'h5A, 1'b0, 1'b1, 1'b1, 4'h3, 4'h0, 1'b0);
        frm(0, 8'h5A, 1'b0, 1'b1, 1'b1, 4'h2, 4'h4, 1'b0);
        wr(PTQ_CFG_OFFSET, 32'h5A32_000F);
        frm(0, 8'h5B, 1'b1, 1'b0, 1'b0, 4'h2, 4'h1, 1'b1);
        $display("check test done");
    endtask
    task automatic t_ports;
        wr(PTQ_SEL_OFFSET, 32'h12);
        wr(PTQ_CFG_OFFSET, 32'h1111_0001);
        wr(PTQ_SEL_OFFSET, 32'h22);
        wr(PTQ_CFG_OFFSET, 32'h2222_0002);
        wr(PTQ_SEL_OFFSET, 32'h20);
        wr(PTQ_CFG_OFFSET, 32'hFFFF_FFFF);
        rdchk(PTQ_CFG_OFFSET, 32'h0, 1'b0);
        wr(PTQ_SEL_OFFSET, 32'h32);
        rdchk(PTQ_CFG_OFFSET, 32'h0, 1'b0);
        wr(PTQ_SEL_OFFSET, 32'h02);
        rdchk(PTQ_CFG_OFFSET, 32'h5A32_000F, 1'b0);
        wr(PTQ_SEL_OFFSET, 32'h22);
        rdchk(PTQ_CFG_OFFSET, 32'h2222_0002, 1'b0);
        rdchk(12'h200, 32'h0, 1'b1);
        frm(1, 8'h00, 1'b0, 1'b1, 1'b0, 4'h1, 4'h0, 1'b1);
        frm(2, 8'h00, 1'b0, 1'b0, 1'b1, 4'h2, 4'h0, 1'b0);
        // Last verdicts: ports 0 and 1 captured, port 2 rejected
        rdchk(PTQ_STAT_OFFSET, 32'h0000_0403, 1'b0);
        $display("port test done");
    endtask
    initial begin
        repeat (5) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_mask();
        t_checks();
        t_ports();
        results();
    end
endmodule // ptq_qualifier_bench
`default_nettype wire
